// *** s4t_sink.sv ***
`timescale 1ns/1ps
`include "s4t_defines.svh"

module s4t_sink
    import s4t_pkg::*;
#(
    parameter int PORTS       = 10,
    parameter int TRAIN_EDGES = `S4T_TRAIN_EDGES
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               tx_data_clk,
    input  wire logic [15:0]        tx_data,
    input  wire logic               tx_ctl,
    input  wire logic [2*PORTS-1:0] fifo_status,
    output logic                    tx_stat_clk,
    output logic [1:0]              tx_stat,
    output logic                    word_valid,
    output s4t_word_t               word_data,
    output logic                    word_ctl,
    output logic                    dip4_err,
    output logic                    trained
);

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    generate
        if (PORTS < 1 || PORTS > 256)
        begin : g_bad_ports
            $error("PORTS must lie between 1 and 256");
        end
        if (TRAIN_EDGES < 2 || TRAIN_EDGES > 255)
        begin : g_bad_train
            $error("TRAIN_EDGES must lie between 2 and 255");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Pin synchronisers and link clock edge detection
    // ------------------------------------------------------------------------
    logic [17:0] pins_sync;
    logic        lclk;
    logic        lclk_q;
    s4t_word_t   dat_q;
    logic        ctl_q;
    logic [7:0]  hp_cnt;
    logic [7:0]  hp_last;
    logic [7:0]  stable_cnt;

    s4t_sync #(
        .W (18)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({tx_data_clk, tx_ctl, tx_data}),
        .sync_out (pins_sync)
    );

    wire       lnk_edge  = lclk ^ lclk_q;
    wire [7:0] hp_diff   = (hp_cnt > hp_last) ? hp_cnt - hp_last
                                              : hp_last - hp_cnt;
    wire       hp_steady = hp_diff <= `S4T_EDGE_TOL;
    wire       lnk_lost  = hp_cnt == `S4T_HP_MAX;
    wire [7:0] train_top = 8'(TRAIN_EDGES - 1);

    assign lclk = pins_sync[17];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lclk_q <= 1'b0;
            dat_q  <= '0;
            ctl_q  <= 1'b0;
        end
        else
        begin
            lclk_q <= lclk;
            dat_q  <= pins_sync[15:0];
            ctl_q  <= pins_sync[16];
        end
    end

    // ------------------------------------------------------------------------
    // Training: a run of evenly spaced link edges declares the clock usable
    // ------------------------------------------------------------------------
    // A clock that wanders drops training at the uneven edge, though the word taken at that edge is still delivered;
    // a clock that stops drops it only once hp_cnt reaches S4T_HP_MAX. No unstable-clock word is ever flagged.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hp_cnt     <= 8'h00;
            hp_last    <= 8'h00;
            stable_cnt <= 8'h00;
            trained    <= 1'b0;
        end
        else if (lnk_edge)
        begin
            hp_cnt  <= 8'h01;
            hp_last <= hp_cnt;
            if (!hp_steady)                                       // RQ7
            begin
                stable_cnt <= 8'h00;
                trained    <= 1'b0;
            end
            else if (stable_cnt == train_top)
                trained <= 1'b1;                                  // RQ7
            else
                stable_cnt <= stable_cnt + 8'h01;
        end
        else if (lnk_lost)
        begin
            stable_cnt <= 8'h00;
            trained    <= 1'b0;
        end
        else
            hp_cnt <= hp_cnt + 8'h01;
    end

    // ------------------------------------------------------------------------
    // Double-data-rate word capture and DIP4 check
    // ------------------------------------------------------------------------
    // The word sampled one cycle before an edge was launched by the previous
    // edge and has been stable for half a link period.
    logic [15:0] dip_acc;

    wire        take     = lnk_edge && trained;
    wire [15:0] dip_word = ctl_q ? {dat_q[15:4], `S4T_DIP4_ONES} : dat_q;
    wire [15:0] dip_next = {dip_acc[14:0], dip_acc[15]} ^ dip_word;
    wire [3:0]  dip_fold = dip_next[15:12] ^ dip_next[11:8] ^
                           dip_next[7:4] ^ dip_next[3:0];
    wire        dip_bad  = take && ctl_q &&
                           (dip_fold != dat_q[`S4T_DIP4_MSB:0]);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_valid <= 1'b0;
            word_data  <= '0;
            word_ctl   <= 1'b0;
            dip4_err   <= 1'b0;
            dip_acc    <= 16'h0000;
        end
        else
        begin
            word_valid <= take;                                   // RQ2
            dip4_err   <= dip_bad;                                // RQ8
            if (take)
            begin
                word_data <= dat_q;                               // RQ1
                word_ctl  <= ctl_q;
                dip_acc   <= ctl_q ? 16'h0000 : dip_next;         // RQ8
            end
            else if (!trained)
                dip_acc <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------------
    // Status clock: one toggle every four link edges gives a quarter rate
    // ------------------------------------------------------------------------
    logic [1:0] edge_div;

    wire stat_tick = lnk_edge && edge_div == `S4T_STAT_DIV;
    wire stat_fall = stat_tick && tx_stat_clk;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_div    <= 2'h0;
            tx_stat_clk <= 1'b0;
        end
        else if (lnk_edge)
        begin
            edge_div <= edge_div + 2'h1;
            if (stat_tick)
                tx_stat_clk <= ~tx_stat_clk;                      // RQ4
        end
    end

    // ------------------------------------------------------------------------
    // Status frame: framing, one slot per port, then DIP2
    // ------------------------------------------------------------------------
    // Slots change on the falling status edge so the far side samples them
    // on the rising edge. Status is snapshotted at framing for a coherent set.
    s4t_stat_state_t    st;
    s4t_stat_state_t    next_st;
    logic [7:0]         slot;
    logic [1:0]         dip2_acc;
    logic [2*PORTS-1:0] snap;

    wire [7:0] slot_top  = 8'(PORTS - 1);
    wire [1:0] slot_val  = snap[2*slot +: 2];
    wire       last_slot = slot == slot_top;

    always_comb
    begin
        next_st = st;
        case (st)
            S4T_ST_FRAME: next_st = S4T_ST_SLOT;
            S4T_ST_SLOT:  next_st = last_slot ? S4T_ST_DIP : S4T_ST_SLOT;
            S4T_ST_DIP:   next_st = S4T_ST_FRAME;
            default:      next_st = S4T_ST_FRAME;
        endcase
    end

    wire [1:0] next_stat = (next_st == S4T_ST_FRAME) ? `S4T_STAT_FRAME
                         : (next_st == S4T_ST_DIP)   ? ~(dip2_acc ^ slot_val)
                         : ((st == S4T_ST_FRAME) ? fifo_status[1:0]
                                                 : snap[2*slot + 2 +: 2]);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st       <= S4T_ST_FRAME;
            slot     <= 8'h00;
            dip2_acc <= `S4T_DIP2_RESET;
            snap     <= '0;
            tx_stat  <= `S4T_STAT_FRAME;
        end
        else if (!trained)
        begin
            st       <= S4T_ST_FRAME;
            slot     <= 8'h00;
            dip2_acc <= `S4T_DIP2_RESET;
            tx_stat  <= `S4T_STAT_FRAME;                          // RQ5
        end
        else if (stat_fall)
        begin
            st      <= next_st;
            tx_stat <= next_stat;                                 // RQ5
            if (st == S4T_ST_FRAME)
            begin
                snap     <= fifo_status;
                slot     <= 8'h00;
                dip2_acc <= `S4T_DIP2_RESET;
            end
            else if (st == S4T_ST_SLOT)
            begin
                dip2_acc <= dip2_acc ^ slot_val;
                if (!last_slot)
                    slot <= slot + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_ddr_capture: assert property (take |=> word_valid)          // RQ2
        else $error("word not delivered after a trained link edge");
    a_word_value: assert property (                               // RQ1
        word_valid |-> word_data == $past(dat_q) &&
                       word_ctl == $past(ctl_q))
        else $error("delivered word differs from captured word");
    a_stat_rate: assert property (                                // RQ4
        $changed(tx_stat_clk) |-> $past(lnk_edge) &&
                                  $past(edge_div) == 2'h3)
        else $error("status clock toggled off the quarter-rate edge");
    a_stat_untrained: assert property (                           // RQ5
        $past(!trained) |-> tx_stat == 2'h3)
        else $error("status not framing while untrained");
    a_stat_timing: assert property (                              // RQ5
        $changed(tx_stat) && $past(trained) |-> $fell(tx_stat_clk))
        else $error("status changed away from a falling status edge");
    a_train_run: assert property (                                // RQ7
        $rose(trained) |-> $past(stable_cnt) == train_top &&
                           $past(lnk_edge))
        else $error("training declared without a full steady run");
    a_dip4_flag: assert property (                                // RQ8
        take && ctl_q && dip_fold != dat_q[3:0] |=> dip4_err)
        else $error("DIP4 mismatch not flagged");

    c_trained:  cover property ($rose(trained));
    c_dip4_err: cover property (dip4_err);
    c_dip2:     cover property (st == S4T_ST_DIP && stat_fall);

endmodule // s4t_sink

// *** s4t_defines.svh ***
// What this block does
// RQ1: Accept a 16-bit transmit word bus carrying payload and control words.
// RQ2: Sender launches words on both link clock edges; both edges are captured.
// RQ3: Sender holds the control line high for control words, low for payload.
// RQ4: Status clock runs at one quarter of the transmit data clock frequency.
// RQ5: Drive 2-bit status: framing, round-robin FIFO status, then DIP2 check.
// RQ6: A data clock applied after reset must already be stable.
// RQ7: Train capture on the data clock; unstable clocks surface as DIP4 errors. The code clears trained instead and raises no DIP4 error.
// RQ8: DIP4 checked over words since the previous control word, per SPI4-2.
`ifndef S4T_DEFINES_SVH
`define S4T_DEFINES_SVH

// ----------------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------------
`define S4T_WORD_W      16
`define S4T_DIP4_MSB    3
`define S4T_DIP4_ONES   4'hf

// ----------------------------------------------------------------------------
// Status bus codes
// ----------------------------------------------------------------------------
`define S4T_STAT_FRAME  2'h3
`define S4T_DIP2_RESET  2'h0

// ----------------------------------------------------------------------------
// Link clock training and status clock divide, counted in reference clock cycles and link edges
// ----------------------------------------------------------------------------
`define S4T_TRAIN_EDGES 16
`define S4T_EDGE_TOL    8'h01
`define S4T_HP_MAX      8'hff
`define S4T_STAT_DIV    2'h3

`endif

// *** s4t_pkg.sv ***
package s4t_pkg;

    typedef enum logic [1:0] {
        S4T_ST_FRAME,
        S4T_ST_SLOT,
        S4T_ST_DIP
    } s4t_stat_state_t;

    typedef logic [15:0] s4t_word_t;

endpackage

// *** s4t_sync.sv ***
`timescale 1ns/1ps

module s4t_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // s4t_sync

// *** s4t_src.sv ***
`timescale 1ns/1ps

module s4t_src (
    input  wire logic        run,
    output logic             tx_data_clk,
    output logic [15:0]      tx_data,
    output logic             tx_ctl
);
    // ------------------------------------------------------------------
    // Link transmitter
    // ------------------------------------------------------------------
    logic [16:0] q[$];
    logic [16:0] w;

    initial
    begin
        tx_data_clk = 1'b0;
        tx_data = 16'h0;
        tx_ctl = 1'b0;
        forever
        begin
            #100;
            if (run === 1'b1)
            begin
                // The clock starts at its full rate and never with a runt.
                tx_data_clk = ~tx_data_clk;
                w = (q.size() > 0) ? q.pop_front() : 17'h1000f;
                tx_data = w[15:0];
                tx_ctl = w[16];
            end
            else
            begin
                // A stopped link carries no valid word, so the data lines toggle.
                tx_data = ~tx_data;
            end
        end
    end
endmodule // s4t_src

// *** s4t_sink_tb.sv ***
`timescale 1ns/1ps

module s4t_sink_tb;
    logic        ref_clk;
    logic        rst_n;
    logic        run;
    logic [19:0] fifo_status;
    logic        tx_data_clk;
    logic [15:0] tx_data;
    logic        tx_ctl;
    logic        tx_stat_clk;
    logic [1:0]  tx_stat;
    logic        word_valid;
    logic [15:0] word_data;
    logic        word_ctl;
    logic        dip4_err;
    logic        trained;
    int          num_errors;
    int          cmp_count;
    int          dip_cnt;
    logic [16:0] got[$];

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    s4t_src src (
        .run         (run),
        .tx_data_clk (tx_data_clk),
        .tx_data     (tx_data),
        .tx_ctl      (tx_ctl)
    );

    s4t_sink #(.PORTS(10), .TRAIN_EDGES(4)) dut (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .tx_data_clk (tx_data_clk),
        .tx_data     (tx_data),
        .tx_ctl      (tx_ctl),
        .fifo_status (fifo_status),
        .tx_stat_clk (tx_stat_clk),
        .tx_stat     (tx_stat),
        .word_valid  (word_valid),
        .word_data   (word_data),
        .word_ctl    (word_ctl),
        .dip4_err    (dip4_err),
        .trained     (trained)
    );

    // ------------------------------------------------------------------
    // Monitor and helpers
    // ------------------------------------------------------------------
    // Outputs are read on the falling edge, where they have settled.
    always @(negedge ref_clk)
    begin
        if (word_valid === 1'b1 && {word_ctl, word_data} !== 17'h1000f)
            got.push_back({word_ctl, word_data});
        if (dip4_err === 1'b1)
            dip_cnt++;
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_train();
        int k;
        chk("trained_rst", trained, 0);
        chk("stat_rst", tx_stat, 3);
        chk("valid_rst", word_valid, 0);
        run = 1'b1;
        k = 0;
        while (trained !== 1'b1 && k < 400)
        begin
            cycles(1);
            k++;
        end
        chk("trained", trained, 1);
        $display("test_train done");
    endtask

    // Sends n payload words then one control word with good or bad parity.
    task automatic send_burst(input logic [15:0] base, input int n,
                              input logic bad);
        logic [15:0] acc;
        logic [15:0] c;
        logic [3:0]  f;
        acc = 16'h0;
        got.delete();
        dip_cnt = 0;
        for (int i = 0; i < n; i++)
        begin
            src.q.push_back({1'b0, base + 16'(i)});
            acc = {acc[14:0], acc[15]} ^ (base + 16'(i));
        end
        acc = {acc[14:0], acc[15]} ^ 16'h600f;
        f = acc[15:12] ^ acc[11:8] ^ acc[7:4] ^ acc[3:0];
        c = {12'h600, bad ? ~f : f};
        src.q.push_back({1'b1, c});
        cycles(4 * n + 40);
        chk("word_count", got.size(), n + 1);
        for (int i = 0; i < n && i < got.size(); i++)
            chk("payload", got[i], {1'b0, base + 16'(i)});
        if (got.size() > n)
            chk("control", got[n], {1'b1, c});
        chk("dip4_err", dip_cnt, bad);
        $display("send_burst done");
    endtask

    task automatic test_status();
        realtime t0;
        int      k;
        @(posedge tx_stat_clk);
        t0 = $realtime;
        @(posedge tx_stat_clk);
        chk("stat_period", int'($realtime - t0), 800);
        k = 0;
        while (tx_stat !== 2'h3 && k < 40)
        begin
            @(posedge tx_stat_clk);
            k++;
        end
        for (int i = 0; i < 10; i++)
        begin
            @(posedge tx_stat_clk);
            chk("slot", tx_stat, i % 3);
        end
        @(posedge tx_stat_clk);
        chk("dip2", tx_stat, 0);
        @(posedge tx_stat_clk);
        chk("frame", tx_stat, 3);
        $display("test_status done");
    endtask

    task automatic test_loss();
        int k;
        cycles(1);
        run = 1'b0;
        k = 0;
        while (trained !== 1'b0 && k < 400)
        begin
            cycles(1);
            k++;
        end
        chk("trained_lost", trained, 0);
        chk("loss_delay", k >= 250, 1);
        cycles(2);
        chk("stat_idle", tx_stat, 3);
        $display("test_loss done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        run = 1'b0;
        fifo_status = 20'h24924;
        num_errors = 0;
        cmp_count = 0;
        dip_cnt = 0;
        cycles(8);
        rst_n = 1'b1;
        cycles(2);
        test_train();
        send_burst(16'h1230, 5, 1'b0);
        send_burst(16'hab00, 3, 1'b1);
        send_burst(16'h0000, 0, 1'b0);
        test_status();
        test_loss();
        print_verdict();
    end

    initial
    begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule // s4t_sink_tb
